//--- pkg/srx_defines.svh
// offsets, field positions, reset values and counts of the receiver gating
`ifndef SRX_DEFINES_SVH
`define SRX_DEFINES_SVH

// register offsets
`define SRX_OFS_CFG_TWO      7'h0A
`define SRX_OFS_BUF_CFG      7'h0B

// receiver_config_two fields
`define SRX_C2_MUTE          7
`define SRX_C2_PREF_EN       6
`define SRX_C2_PSEL_HI       5
`define SRX_C2_PSEL_LO       4
`define SRX_C2_NONAUDIO      1
`define SRX_C2_INVALID       0
`define SRX_C2_MASK          8'hF3
`define SRX_C2_RESET         8'h00

// receiver_buffer_config fields
`define SRX_BC_TAPE_ONLY     5
`define SRX_BC_SPLIT         4
`define SRX_BC_CHANGE        3
`define SRX_BC_MODE_HI       2
`define SRX_BC_MODE_LO       1
`define SRX_BC_SIZE          0
`define SRX_BC_MASK          8'h3F
`define SRX_BC_RESET         8'h00

// channel-status block and user buffer sizes
`define SRX_CS_FRAMES        192
`define SRX_CS_BITS_KEPT     40
`define SRX_UBUF_SMALL       384
`define SRX_UBUF_LARGE       768

`endif

//--- pkg/srx_pkg.sv
// types of the receiver gating and user-bit buffering block
package srx_pkg;
	// user buffer modes
	typedef enum logic [1:0] {
		SRX_UMODE_DISCARD,
		SRX_UMODE_DOUBLE,
		SRX_UMODE_FORMAT,
		SRX_UMODE_RESERVED
	} srx_umode_e;

	// pll reference port choice
	typedef enum logic [1:0] {
		SRX_REF_PLAYBACK,
		SRX_REF_AUX_IN,
		SRX_REF_RECORD,
		SRX_REF_AUX_OUT
	} srx_ref_e;
endpackage : srx_pkg

//--- src/srx_skid.sv
// two-entry buffer between receiver gating and the rate converter
`timescale 1ns/1ps
module srx_skid #(
	parameter int WIDTH = 24
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] slot_reg [0:1];  // storage
	logic             rd_ptr_reg;      // next slot to drain
	logic             wr_ptr_reg;      // next slot to fill
	logic [1:0]       count_reg;       // words held
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// ready and valid are plain decodes of the count register
	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data  = slot_reg[rd_ptr_reg];

	// pointers and count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// data slots, no reset needed
	always_ff @(posedge core_clk) begin
		if (push)
			slot_reg[wr_ptr_reg] <= in_data;
	end
endmodule : srx_skid

//--- src/srx_cs_tracker.sv
// channel-status block collection and block flag
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_cs_tracker (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// frame stream, channel A subframes only
	input  wire logic        frame_stb,
	input  wire logic        block_start,
	input  wire logic        cs_bit,
	// control
	input  wire logic        change_mode,
	input  wire logic        flag_clear,
	// results
	output logic             status_block_flag,
	output logic [7:0]       cs_byte0,
	output logic [7:0]       cs_byte1
);
	logic [7:0]  frame_cnt_reg;    // frame in block
	logic        in_block_reg;     // aligned to a Z preamble
	logic [39:0] cur_reg;          // first five bytes being built
	logic [39:0] prev_reg;         // first five bytes of last block
	logic        flag_reg;         // sticky block flag
	wire  [7:0]  frame_idx = block_start ? 8'h00 : frame_cnt_reg;
	wire         active    = frame_stb && (block_start || in_block_reg);
	wire         block_end = active &&
		(frame_idx == 8'(`SRX_CS_FRAMES - 1));
	// last bits of the fifth byte land in the closing compare
	wire  [39:0] cur_full  = cur_reg;
	wire         differs   = (cur_full != prev_reg);
	wire         set_flag  = block_end && (!change_mode || differs);

	assign status_block_flag = flag_reg;
	assign cs_byte0 = prev_reg[7:0];
	assign cs_byte1 = prev_reg[15:8];

	// frame counter, realigned at each Z
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_cnt_reg <= 8'h00;
			in_block_reg  <= 1'b0;
		end else if (active) begin
			frame_cnt_reg <= block_end ? 8'h00 : frame_idx + 8'h01;
			in_block_reg  <= !block_end;
		end
	end

	// collect bits, lsb of byte 0 first
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_reg  <= 40'h0;
			prev_reg <= 40'h0;
		end else begin
			if (active && frame_idx < 8'(`SRX_CS_BITS_KEPT))
				cur_reg[frame_idx[5:0]] <= cs_bit;
			if (block_end)
				prev_reg <= cur_reg;
		end
	end

	// sticky flag, a set beats a clear in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			flag_reg <= 1'b0;
		else if (set_flag)
			flag_reg <= 1'b1;
		else if (flag_clear)
			flag_reg <= 1'b0;
	end
endmodule : srx_cs_tracker

//--- src/srx_top.sv
// receiver output gating, pll reference choice and user-bit buffering
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_top #(
	parameter int         SAMPLE_W     = 24,
	parameter logic [6:0] TAPE_CATEGORY = 7'h03
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	// register port from the control interface
	input  wire logic [6:0]          reg_addr,
	input  wire logic                reg_wr_en,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_rd_en,
	output logic [7:0]               reg_rdata,
	output logic                     reg_rd_valid,
	input  wire logic                status_flag_clear,
	// left/right clock pins
	input  wire logic                preamble_lrclk,
	input  wire logic                playback_lrclk,
	input  wire logic                aux_in_lrclk,
	input  wire logic                record_lrclk,
	input  wire logic                aux_out_lrclk,
	output logic                     pll_ref_lrclk,
	// decoded receiver subframes
	input  wire logic                rx_valid,
	output logic                     rx_ready,
	input  wire logic [SAMPLE_W-1:0] rx_sample,
	input  wire logic                rx_chan_b,
	input  wire logic                rx_block_start,
	input  wire logic                rx_validity,
	input  wire logic                rx_user_bit,
	input  wire logic                rx_cs_bit,
	input  wire logic                rx_non_audio,
	input  wire logic                rx_compressed,
	// receiver audio output
	output logic                     aud_valid,
	output logic [SAMPLE_W-1:0]      aud_sample,
	// rate converter input
	output logic                     src_valid,
	input  wire logic                src_ready,
	output logic [SAMPLE_W-1:0]      src_sample,
	// user bits
	input  wire logic [10:0]         user_rd_addr,
	output logic                     user_rd_data,
	output logic                     user_buf_done,
	output logic                     user_buf_which,
	output logic                     user_iu_valid,
	output logic [7:0]               user_iu_data,
	output logic                     user_bit_event,
	// channel status
	output logic                     status_block_flag,
	output logic                     professional_flag,
	output logic [3:0]               pro_user_format
);
	import srx_pkg::*;

	// register file
	logic [7:0] cfg_two_reg;            // receiver_config_two
	logic [7:0] buf_cfg_reg;            // receiver_buffer_config
	logic [7:0] rdata_reg;              // read data
	logic       rd_valid_reg;           // read answer strobe

	// decoded controls
	wire        receiver_hard_silence = cfg_two_reg[`SRX_C2_MUTE];
	wire        port_reference_enable = cfg_two_reg[`SRX_C2_PREF_EN];
	srx_ref_e   reference_port_choice;
	wire        block_non_audio       = cfg_two_reg[`SRX_C2_NONAUDIO];
	wire        block_invalid_samples = cfg_two_reg[`SRX_C2_INVALID];
	wire        tape_id_interrupt_only = buf_cfg_reg[`SRX_BC_TAPE_ONLY];
	wire        user_bits_split       = buf_cfg_reg[`SRX_BC_SPLIT];
	wire        status_interrupt_on_change = buf_cfg_reg[`SRX_BC_CHANGE];
	srx_umode_e user_buffer_mode;
	wire        user_buffer_size      = buf_cfg_reg[`SRX_BC_SIZE];

	// multi-bit fields seen through their enum types
	assign reference_port_choice =
		srx_ref_e'(cfg_two_reg[`SRX_C2_PSEL_HI:`SRX_C2_PSEL_LO]);
	assign user_buffer_mode =
		srx_umode_e'(buf_cfg_reg[`SRX_BC_MODE_HI:`SRX_BC_MODE_LO]);

	// address decode
	wire hit_two = (reg_addr == `SRX_OFS_CFG_TWO);
	wire hit_buf = (reg_addr == `SRX_OFS_BUF_CFG);
	// unmapped offsets read back as zero
	wire [7:0] rd_mux = hit_two ? cfg_two_reg :
		hit_buf ? buf_cfg_reg : 8'h00;

	// writes keep only defined bits
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_two_reg <= `SRX_C2_RESET;
			buf_cfg_reg <= `SRX_BC_RESET;
		end else if (reg_wr_en) begin
			if (hit_two)
				cfg_two_reg <= reg_wdata & `SRX_C2_MASK;
			if (hit_buf)
				buf_cfg_reg <= reg_wdata & `SRX_BC_MASK;
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg    <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= reg_rd_en;
			if (reg_rd_en)
				rdata_reg <= rd_mux;
		end
	end
	assign reg_rdata    = rdata_reg;
	assign reg_rd_valid = rd_valid_reg;

	// pin synchronisers: three stages, value taken when last two agree
	logic [4:0] pin_s1_reg;             // first stage, read by stage two
	logic [4:0] pin_s2_reg;             // second stage
	logic [4:0] pin_s3_reg;             // third stage
	logic [4:0] pin_val_reg;            // accepted levels
	wire  [4:0] pin_raw = {aux_out_lrclk, record_lrclk, aux_in_lrclk,
		playback_lrclk, preamble_lrclk};
	// a level counts once stages two and three agree
	wire  [4:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_reg  <= 5'h00;
			pin_s2_reg  <= 5'h00;
			pin_s3_reg  <= 5'h00;
			pin_val_reg <= 5'h00;
		end else begin
			pin_s1_reg  <= pin_raw;
			pin_s2_reg  <= pin_s1_reg;
			pin_s3_reg  <= pin_s2_reg;
			pin_val_reg <= (pin_s3_reg & pin_agree) |
				(pin_val_reg & ~pin_agree);
		end
	end

	// pll reference selection
	logic pll_ref_reg;                  // chosen left/right clock
	wire  port_lr = pin_val_reg[3'(reference_port_choice) + 3'h1];
	wire  ref_next = port_reference_enable ? port_lr : pin_val_reg[0];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			pll_ref_reg <= 1'b0;
		else
			pll_ref_reg <= ref_next;
	end
	assign pll_ref_lrclk = pll_ref_reg;

	// sample path: accept only while the buffer can take a word
	logic skid_ready;                   // buffer has room
	assign rx_ready = skid_ready;
	wire take = rx_valid && skid_ready;
	// gated words are still taken, only the converter misses them
	wire drop = rx_compressed ||
		(block_non_audio && rx_non_audio) ||
		(block_invalid_samples && rx_validity);
	// silence replaces the sample on both outputs
	wire [SAMPLE_W-1:0] heard = receiver_hard_silence ?
		'0 : rx_sample;

	srx_skid #(
		.WIDTH(SAMPLE_W)
	) u_skid (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.in_valid (rx_valid && !drop),
		.in_ready (skid_ready),
		.in_data  (heard),
		.out_valid(src_valid),
		.out_ready(src_ready),
		.out_data (src_sample)
	);

	// receiver audio output
	logic                aud_valid_reg;  // sample strobe
	logic [SAMPLE_W-1:0] aud_sample_reg; // muted or passed sample

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aud_valid_reg  <= 1'b0;
			aud_sample_reg <= '0;
		end else begin
			aud_valid_reg <= take;
			if (take)
				aud_sample_reg <= heard;
		end
	end
	assign aud_valid  = aud_valid_reg;
	assign aud_sample = aud_sample_reg;

	// channel status block collection
	logic [7:0] cs_byte0;               // completed block byte 0
	logic [7:0] cs_byte1;               // completed block byte 1

	srx_cs_tracker u_cs (
		.core_clk         (core_clk),
		.arst_n           (arst_n),
		.frame_stb        (take && !rx_chan_b),
		.block_start      (rx_block_start),
		.cs_bit           (rx_cs_bit),
		.change_mode      (status_interrupt_on_change),
		.flag_clear       (status_flag_clear),
		.status_block_flag(status_block_flag),
		.cs_byte0         (cs_byte0),
		.cs_byte1         (cs_byte1)
	);

	// professional flag and format come from the last whole block
	wire pro_now = cs_byte0[0];
	// tape category is a consumer-only code in byte 1
	wire tape_cat = !pro_now && (cs_byte1[6:0] == TAPE_CATEGORY);
	assign professional_flag = pro_now;
	assign pro_user_format   = cs_byte1[7:4];

	// double user buffer
	logic       user_mem [0:2*`SRX_UBUF_LARGE-1]; // two buffers
	logic [9:0] ucnt_reg;               // bits in current buffer
	logic [9:0] ucnt_a_reg;             // channel A bits, split mode
	logic [9:0] ucnt_b_reg;             // channel B bits, split mode
	logic       ubuf_sel_reg;           // buffer being filled
	logic       uarmed_reg;             // waiting ended at a Z
	logic       udone_reg;              // buffer full strobe
	logic       uwhich_reg;             // buffer that just filled
	logic       urd_reg;                // read data
	// buffer length and the slot of the next user bit
	wire  [9:0] usize = user_buffer_size ? 10'(`SRX_UBUF_LARGE) :
		10'(`SRX_UBUF_SMALL);
	wire  [9:0] uhalf = {1'b0, usize[9:1]};
	wire        dbl_mode = (user_buffer_mode == SRX_UMODE_DOUBLE);
	wire        ustart = take && rx_block_start;
	// writing starts at a taken Z and stops once the buffer fills
	wire        uwrite = dbl_mode && take && (uarmed_reg || ustart);
	wire  [9:0] uc_tot = ustart ? 10'h000 : ucnt_reg;
	wire  [9:0] uc_a   = ustart ? 10'h000 : ucnt_a_reg;
	wire  [9:0] uc_b   = ustart ? 10'h000 : ucnt_b_reg;
	wire  [9:0] upos   = !user_bits_split ? uc_tot :
		(rx_chan_b ? uhalf + uc_b : uc_a);
	// second buffer sits above the largest first buffer
	wire  [10:0] uaddr = 11'(upos) +
		(ubuf_sel_reg ? 11'(`SRX_UBUF_LARGE) : 11'h000);
	// last slot of the buffer in use
	wire        ufull = uwrite && (uc_tot == usize - 10'h001);

	// fill, then switch to the other buffer and wait for next Z
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ucnt_reg     <= 10'h000;
			ucnt_a_reg   <= 10'h000;
			ucnt_b_reg   <= 10'h000;
			ubuf_sel_reg <= 1'b0;
			uarmed_reg   <= 1'b0;
			udone_reg    <= 1'b0;
			uwhich_reg   <= 1'b0;
		end else begin
			udone_reg <= ufull;
			if (!dbl_mode) begin
				uarmed_reg <= 1'b0;
			end else if (ufull) begin
				ucnt_reg     <= 10'h000;
				uarmed_reg   <= 1'b0;
				uwhich_reg   <= ubuf_sel_reg;
				ubuf_sel_reg <= ~ubuf_sel_reg;
			end else if (uwrite) begin
				uarmed_reg <= 1'b1;
				ucnt_reg   <= uc_tot + 10'h001;
				ucnt_a_reg <= rx_chan_b ? uc_a : uc_a + 10'h001;
				ucnt_b_reg <= rx_chan_b ? uc_b + 10'h001 : uc_b;
			end
		end
	end

	// user bit storage and read port
	always_ff @(posedge core_clk) begin
		if (uwrite)
			user_mem[uaddr] <= rx_user_bit;
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			urd_reg <= 1'b0;
		else
			urd_reg <= user_mem[user_rd_addr];
	end
	assign user_rd_data   = urd_reg;
	assign user_buf_done  = udone_reg;
	assign user_buf_which = uwhich_reg;

	// formatted user data
	logic [7:0] ushift_reg;             // bits of the unit in work
	logic [3:0] ubits_reg;              // bits held
	logic       iu_valid_reg;           // unit strobe
	logic [7:0] iu_data_reg;            // last unit
	logic       last_id_reg;            // previous ID bit
	logic       event_reg;              // user-bit interrupt strobe
	wire        fmt_mode = (user_buffer_mode == SRX_UMODE_FORMAT);
	wire        fbit = fmt_mode && take;
	// consumer units begin at a one; professional bytes start at Z
	wire        f_idle = (ubits_reg == 4'h0);
	wire        f_skip = f_idle && !pro_now && !rx_user_bit;
	wire        f_restart = pro_now && rx_block_start;
	wire [3:0]  f_cnt = f_restart ? 4'h0 : ubits_reg;
	wire [7:0]  f_shift = {ushift_reg[6:0], rx_user_bit};
	// unit complete on its eighth bit
	wire        f_done = fbit && !f_skip && (f_cnt == 4'h7);
	wire        id_bit = f_shift[6];
	// tape category in consumer format: events only on ID changes
	wire        id_only = tape_id_interrupt_only && !pro_now && tape_cat;
	wire        unit_evt = f_done &&
		(!id_only || (id_bit != last_id_reg));

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ushift_reg   <= 8'h00;
			ubits_reg    <= 4'h0;
			iu_valid_reg <= 1'b0;
			iu_data_reg  <= 8'h00;
			last_id_reg  <= 1'b0;
			event_reg    <= 1'b0;
		end else begin
			iu_valid_reg <= f_done;
			// event on each unit (only on ID changes when id_only), or on a full buffer in mode 01
			event_reg    <= unit_evt || (ufull && dbl_mode);
			if (!fmt_mode) begin
				ubits_reg <= 4'h0;
			end else if (fbit && !f_skip) begin
				ushift_reg <= f_shift;
				ubits_reg  <= f_done ? 4'h0 : f_cnt + 4'h1;
				if (f_done) begin
					iu_data_reg <= f_shift;
					last_id_reg <= id_bit;
				end
			end
		end
	end
	assign user_iu_valid  = iu_valid_reg;
	assign user_iu_data   = iu_data_reg;
	assign user_bit_event = event_reg;
endmodule : srx_top

//--- verif/srx_props.sv
// port assertions of the receiver gating block
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_props #(
	parameter int SAMPLE_W = 24
) (
	// clock and reset
	input wire logic                core_clk,
	input wire logic                arst_n,
	// register port
	input wire logic [6:0]          reg_addr,
	input wire logic                reg_wr_en,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_rd_en,
	input wire logic [7:0]          reg_rdata,
	input wire logic                reg_rd_valid,
	input wire logic                status_flag_clear,
	// left/right clocks
	input wire logic                preamble_lrclk,
	input wire logic                playback_lrclk,
	input wire logic                aux_in_lrclk,
	input wire logic                record_lrclk,
	input wire logic                aux_out_lrclk,
	input wire logic                pll_ref_lrclk,
	// stream
	input wire logic                rx_valid,
	input wire logic                rx_ready,
	input wire logic [SAMPLE_W-1:0] rx_sample,
	input wire logic                rx_validity,
	input wire logic                rx_non_audio,
	input wire logic                rx_compressed,
	input wire logic                aud_valid,
	input wire logic [SAMPLE_W-1:0] aud_sample,
	input wire logic                src_valid,
	input wire logic                src_ready,
	input wire logic [SAMPLE_W-1:0] src_sample,
	input wire logic                status_block_flag
);
	logic [7:0] c2_q;   // shadow of receiver_config_two
	logic [3:0] ports;  // serial port clocks by choice code
	logic       take;   // subframe accepted
	logic       drop;   // subframe kept from the converter
	logic       pin;    // clock the reference must follow
	assign take = rx_valid && rx_ready;
	assign drop = rx_compressed || (c2_q[1] && rx_non_audio)
		|| (c2_q[0] && rx_validity);
	assign ports = {aux_out_lrclk, record_lrclk, aux_in_lrclk, playback_lrclk};
	assign pin = c2_q[6] ? ports[c2_q[5:4]] : preamble_lrclk;

	// shadow follows every write to the config-two offset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			c2_q <= 8'h00;
		else if (reg_wr_en && reg_addr == `SRX_OFS_CFG_TWO)
			c2_q <= reg_wdata & `SRX_C2_MASK;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_cfg_read: assert property (reg_rd_en && reg_addr == `SRX_OFS_CFG_TWO
		|=> reg_rd_valid && reg_rdata == $past(c2_q)) else $error("config read");
	chk_aud_pass: assert property (take && !c2_q[7]
		|=> aud_valid && aud_sample == $past(rx_sample)) else $error("audio lost");
	chk_mute_zero: assert property (take && c2_q[7]
		|=> aud_valid && aud_sample == '0) else $error("mute leaked");
	chk_aud_idle: assert property (!take |=> !aud_valid)
		else $error("stray audio");
	chk_src_drop: assert property (take && drop && !src_valid
		|=> !src_valid) else $error("gated word passed");
	chk_src_keep: assert property (take && !drop && !src_valid
		|=> src_valid) else $error("word not forwarded");
	chk_src_hold: assert property (src_valid && !src_ready
		|=> src_valid && $stable(src_sample)) else $error("word not held");
	chk_full_stop: assert property (take && src_valid && !src_ready
		|=> !rx_ready) else $error("full buffer took");
	chk_pll_ref: assert property (($stable(pin) && $stable(c2_q))[*8]
		|-> pll_ref_lrclk == pin) else $error("wrong reference");
	chk_flag_hold: assert property (status_block_flag && !status_flag_clear
		|=> status_block_flag) else $error("flag dropped");
endmodule : srx_props

//--- verif/srx_src_model.sv
// behavioural source of decoded receiver subframes
`timescale 1ns/1ps
module srx_src_model #(
	parameter int SAMPLE_W = 24
) (
	// clock and handshake
	input  wire logic           core_clk,
	input  wire logic           rx_ready,
	// subframe and its flags
	output logic                rx_valid,
	output logic [SAMPLE_W-1:0] rx_sample,
	output logic                rx_chan_b,
	output logic                rx_block_start,
	output logic                rx_validity,
	output logic                rx_user_bit,
	output logic                rx_cs_bit,
	output logic                rx_non_audio,
	output logic                rx_compressed
);
	// idle until asked
	initial begin
		{rx_valid, rx_sample, rx_chan_b, rx_block_start} = '0;
		{rx_validity, rx_user_bit, rx_cs_bit, rx_non_audio, rx_compressed} = '0;
	end

	// n subframes, A then B; fl = non-audio, compressed, invalid, cs bit
	task automatic send(input int n, input logic [SAMPLE_W-1:0] base,
		input logic [3:0] fl, input bit z);
		logic ok;
		for (int i = 0; i < n; i++) begin
			rx_valid = 1'b1;
			rx_sample = base + SAMPLE_W'(i);
			rx_chan_b = i[0];
			rx_block_start = z && (i % 384 == 0);
			{rx_non_audio, rx_compressed, rx_validity, rx_cs_bit} = fl;
			rx_user_bit = i[1];
			// hold until the edge that sees ready
			do begin
				ok = rx_ready;
				@(posedge core_clk);
				#1;
			end while (!ok);
		end
		rx_valid = 1'b0;
		// released lines stop showing the last word
		{rx_sample, rx_cs_bit, rx_non_audio} = ~{rx_sample, rx_cs_bit, rx_non_audio};
	endtask : send
endmodule : srx_src_model

//--- verif/testbench.sv
// self-checking bench of the receiver gating block
`timescale 1ns/1ps
module testbench;
	logic        core_clk, arst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic        status_flag_clear, pll_ref_lrclk, status_block_flag;
	logic [4:0]  pins;  // aux out, record, aux in, playback, preamble
	logic        rx_valid, rx_ready, rx_chan_b, rx_block_start, rx_validity;
	logic        rx_user_bit, rx_cs_bit, rx_non_audio, rx_compressed;
	logic [23:0] rx_sample, aud_sample, src_sample;
	logic        aud_valid, src_valid, src_ready, user_buf_done;
	int          n_errors, checks, n_src, n_done, cyc, n0;
	logic [10:0] user_rd_addr;
	logic        user_rd_data, user_buf_which, user_iu_valid;
	logic        user_bit_event, professional_flag;
	logic [7:0]  user_iu_data;
	logic [3:0]  pro_user_format;
	// config bits 1:0, non-audio, compressed, invalid, expect passed
	logic [5:0]  gate [6] = '{6'b001011, 6'b101000, 6'b100011,
		6'b000100, 6'b010010, 6'b011001};

	srx_src_model u_src (.*);
	srx_top dut (.*, .preamble_lrclk(pins[0]), .playback_lrclk(pins[1]),
		.aux_in_lrclk(pins[2]), .record_lrclk(pins[3]), .aux_out_lrclk(pins[4]));

	// 50 ns clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// counts taken where outputs are settled, plus the hang limit
	always @(negedge core_clk) begin
		n_src += int'(src_valid && src_ready);
		n_done += int'(user_buf_done === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("CHECK FAILED t=%0t timeout", $time);
			close_out();
		end
	end

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
		end
	endtask : tick

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
		tick(1);
		reg_wr_en = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		{reg_addr, reg_rd_en} = {a, 1'b1};
		tick(1);
		reg_rd_en = 1'b0;
		check(reg_rd_valid, 1'b1);
		check(reg_rdata, exp);
		tick(1);
	endtask : rd

	task automatic close_out();
		$display("counts: %0d checks, %0d errors", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	initial begin
		{arst_n, reg_wr_en, reg_rd_en, status_flag_clear} = '0;
		{reg_addr, reg_wdata, pins, src_ready, user_rd_addr} = '0;
		{n_errors, checks, n_src, n_done, cyc} = '0;
		repeat (10) @(posedge core_clk);
		#1 arst_n = 1'b1;
		// reset values, masking, unmapped place
		rd(7'h0A, 8'h00);
		rd(7'h0B, 8'h00);
		wr(7'h0A, 8'hFF);
		wr(7'h0B, 8'hFF);
		wr(7'h0C, 8'hFF);
		rd(7'h0A, 8'hF3);
		rd(7'h0B, 8'h3F);
		rd(7'h0C, 8'h00);
		$display("test registers done");
		// hard silence on and off
		src_ready = 1'b1;
		wr(7'h0A, 8'h80);
		u_src.send(2, 24'h123450, 4'h0, 1'b0);
		check(aud_valid, 1'b1);
		check(aud_sample, 24'h000000);
		wr(7'h0A, 8'h00);
		u_src.send(2, 24'h123450, 4'h0, 1'b0);
		check(aud_sample, 24'h123451);
		$display("test mute done");
		// converter gating by control and by flags
		foreach (gate[k]) begin
			wr(7'h0A, {6'h00, gate[k][5:4]});
			n0 = n_src;
			u_src.send(2, 24'h000100, {gate[k][3:1], 1'b0}, 1'b0);
			tick(3);
			check(24'(n_src - n0), gate[k][0] ? 24'd2 : 24'd0);
		end
		$display("test gating done");
		// converter stalls: buffer fills, refuses, then drains
		wr(7'h0A, 8'h00);
		src_ready = 1'b0;
		u_src.send(2, 24'h000200, 4'h0, 1'b0);
		check(rx_ready, 1'b0);
		check(src_valid, 1'b1);
		check(src_sample, 24'h000200);
		n0 = n_src;
		src_ready = 1'b1;
		tick(4);
		check(24'(n_src - n0), 24'd2);
		check(src_valid, 1'b0);
		$display("test buffer done");
		// pll reference from preambles, then each port
		for (int k = 0; k < 5; k++) begin
			wr(7'h0A, k == 0 ? 8'h00 : {2'b01, 2'(k - 1), 4'h0});
			pins = 5'b00001 << k;
			tick(8);
			check(pll_ref_lrclk, 1'b1);
			pins = ~pins;
			tick(8);
			check(pll_ref_lrclk, 1'b0);
		end
		$display("test reference done");
		// status blocks and user buffer modes
		wr(7'h0A, 8'h00);
		wr(7'h0B, 8'h02);
		n0 = n_done;
		u_src.send(384, 24'h0, 4'h0, 1'b1);
		tick(4);
		check(status_block_flag, 1'b1);
		check(24'(n_done - n0), 24'd1);
		check(user_buf_which, 1'b0);
		user_rd_addr = 11'h002;
		tick(1);
		check(user_rd_data, 1'b1);
		user_rd_addr = 11'h001;
		tick(1);
		check(user_rd_data, 1'b0);
		status_flag_clear = 1'b1;
		tick(1);
		status_flag_clear = 1'b0;
		tick(1);
		check(status_block_flag, 1'b0);
		wr(7'h0B, 8'h08);
		n0 = n_done;
		u_src.send(384, 24'h0, 4'h0, 1'b1);
		tick(4);
		check(status_block_flag, 1'b0);
		// consumer units begin at a one: bits 0011.. give CC
		wr(7'h0B, 8'h04);
		u_src.send(16, 24'h0, 4'h0, 1'b1);
		check(professional_flag, 1'b0);
		check(user_iu_data, 8'hCC);
		wr(7'h0B, 8'h0E);
		u_src.send(384, 24'h0, 4'h1, 1'b1);
		tick(4);
		check(status_block_flag, 1'b1);
		check(24'(n_done - n0), 24'd0);
		$display("test status done");
		// professional bytes realign at Z: bits 0011.. give 33
		wr(7'h0B, 8'h04);
		u_src.send(16, 24'h0, 4'h0, 1'b1);
		check(professional_flag, 1'b1);
		check(pro_user_format, 4'hF);
		check(user_iu_data, 8'h33);
		check(user_iu_valid, 1'b1);
		check(user_bit_event, 1'b1);
		$display("test user format done");
		close_out();
	end
endmodule : testbench

bind srx_top srx_props #(.SAMPLE_W(SAMPLE_W)) u_props (.*);
